// file: core/cpc_cfg_regs.sv
// Configuration space upper bank: plant code, scratch, status alias, capability list
`default_nettype none
module cpc_cfg_regs
  import cpc_pkg::*;
#(
  parameter logic [3:0] PLANT_CODE   = 4'hA,  // Arbitrary value
  parameter logic [3:0] REV_MINOR    = 4'h0,
  parameter logic [3:0] REV_MAJOR    = 4'h1,
  parameter logic       SBA_SUPPORT  = 1'b1
) (
  // Clock and reset
  input  wire logic        clk,
  input  wire logic        rst_n,
  // Configuration access port
  input  wire logic        cfg_req,
  input  wire logic        cfg_we,
  input  wire logic [7:0]  cfg_addr,
  input  wire logic [3:0]  cfg_be,
  input  wire logic [31:0] cfg_wdata,
  output logic      [31:0] cfg_rdata,
  output logic             cfg_ack,
  // Device-side inputs
  input  wire logic        gp_strap_en,
  input  wire logic [31:0] mmio_status,
  input  wire logic        graphics_port_reset,
  input  wire logic [7:0]  pwr_data_value,
  // Programmed controls
  output logic             gp_enable,
  output logic      [2:0]  gp_rate,
  output logic             above_4gb_enable,
  output logic             sideband_enable,
  output logic      [7:0]  gp_request_depth,
  output logic      [1:0]  power_state
);

  // Reset release
  logic rst_meta_reg;
  logic rst_sync_n;

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      rst_meta_reg <= 1'b0;
      rst_sync_n   <= 1'b0;
    end else begin
      rst_meta_reg <= 1'b1;
      rst_sync_n   <= rst_meta_reg;
    end
  end

  // Strap pin
  logic strap_sync;

  cpc_sync #(
    .WIDTH (1)
  ) u_strap_sync (
    .clk      (clk),
    .rst_n    (rst_sync_n),
    .async_in (gp_strap_en),
    .sync_out (strap_sync)
  );

  // Address decode
  wire sel_cap_ptr   = (cfg_addr == CPC_OFF_CAP_PTR);
  wire sel_plant     = (cfg_addr == CPC_OFF_PLANT_CODE);
  wire sel_status    = (cfg_addr == CPC_OFF_STATUS_ALIAS);
  wire sel_scratch   = (cfg_addr == CPC_OFF_SCRATCHPAD);
  wire sel_gp_id     = (cfg_addr == CPC_OFF_GP_CAP_ID);
  wire sel_gp_caps   = (cfg_addr == CPC_OFF_GP_CAPS);
  wire sel_gp_ctrl   = (cfg_addr == CPC_OFF_GP_CTRL);
  wire sel_pwr_id    = (cfg_addr == CPC_OFF_PWR_CAP_ID);
  wire sel_pwr_ctrl  = (cfg_addr == CPC_OFF_PWR_CTRL);
  wire wr_strobe     = cfg_req && cfg_we;

  // Byte-enable mask
  wire [31:0] be_mask = {{8{cfg_be[3]}}, {8{cfg_be[2]}}, {8{cfg_be[1]}}, {8{cfg_be[0]}}};

  // Stored registers
  logic [27:0] plant_scratch_reg;
  logic [31:0] scratchpad_reg;
  logic [31:0] gp_ctrl_reg;

  wire [31:0] plant_word   = {plant_scratch_reg, PLANT_CODE};
  wire [31:0] plant_merged = (plant_word & ~be_mask) | (cfg_wdata & be_mask);
  wire [31:0] scr_merged   = (scratchpad_reg & ~be_mask) | (cfg_wdata & be_mask);
  wire [31:0] gpc_merged   = (gp_ctrl_reg & ~be_mask) | (cfg_wdata & be_mask);

  // Writable control bits of the graphics port control word
  wire [31:0] gpc_wmask = {8'hFF, 14'h0000, 2'b11, 2'b00, 1'b1, 2'b00, 3'b111};

  always_ff @(posedge clk or negedge rst_sync_n) begin
    if (!rst_sync_n) begin
      plant_scratch_reg <= CPC_PLANT_SCRATCH_RST;
      scratchpad_reg    <= CPC_SCRATCH_RST;
    end else begin
      if (wr_strobe && sel_plant) begin
        plant_scratch_reg <= plant_merged[31:4];
      end
      if (wr_strobe && sel_scratch) begin
        scratchpad_reg <= scr_merged;
      end
    end
  end

  // Graphics port control: disabled strap blocks writes as well as reads
  wire gpc_write = wr_strobe && sel_gp_ctrl && strap_sync;

  always_ff @(posedge clk or negedge rst_sync_n) begin
    if (!rst_sync_n) begin
      gp_ctrl_reg <= '0;
    end else if (graphics_port_reset) begin
      gp_ctrl_reg[CPC_GPC_EN_BIT] <= 1'b0;
    end else if (gpc_write) begin
      gp_ctrl_reg <= gpc_merged & gpc_wmask;
    end
  end

  // Power control
  logic [31:0] pwr_word;
  logic [1:0]  pwr_state_int;
  wire  [31:0] pwr_merged = (pwr_word & ~be_mask) | (cfg_wdata & be_mask);

  cpc_pwr_ctrl u_pwr_ctrl (
    .clk         (clk),
    .rst_n       (rst_sync_n),
    .wr_en       (wr_strobe && sel_pwr_ctrl),
    .wr_data     (pwr_merged),
    .data_value  (pwr_data_value),
    .power_state (pwr_state_int),
    .rd_word     (pwr_word)
  );

  // Read-only capability words
  wire [31:0] cap_ptr_word = strap_sync ? CPC_CAP_PTR_GP : CPC_CAP_PTR_PWR;
  wire [31:0] gp_id_word   = {8'h00, REV_MAJOR, REV_MINOR, CPC_GP_NEXT_PTR, CPC_GP_CAP_ID};
  wire [31:0] gp_caps_word = {CPC_GP_REQUEST_QUEUE_DEPTH_DEF, 14'h0000, SBA_SUPPORT, 3'b000,
                              CPC_GP_4GB_DEF, 2'b00, CPC_GP_RATES_DEF};
  wire [31:0] pwr_id_word  = {5'h00, 1'b0, 1'b0, 3'b000, 1'b1, 1'b0, 1'b0,
                              CPC_PWR_VERSION, CPC_PWR_NEXT_PTR, CPC_PWR_CAP_ID};

  // Graphics port words are gated by the strap
  wire [31:0] gp_gate = {32{strap_sync}};

  // Read mux; list order is pointer, graphics port entry (strap set only), power entry
  wire [31:0] rd_mux =
      sel_cap_ptr  ? cap_ptr_word :
      sel_plant    ? plant_word :
      sel_status   ? mmio_status :
      sel_scratch  ? scratchpad_reg :
      sel_gp_id    ? (gp_id_word & gp_gate) :
      sel_gp_caps  ? (gp_caps_word & gp_gate) :
      sel_gp_ctrl  ? (gp_ctrl_reg & gp_gate) :
      sel_pwr_id   ? pwr_id_word :
      sel_pwr_ctrl ? pwr_word :
      32'h0000_0000;

  // Answer one cycle after the request
  always_ff @(posedge clk or negedge rst_sync_n) begin
    if (!rst_sync_n) begin
      cfg_ack   <= 1'b0;
      cfg_rdata <= '0;
    end else begin
      cfg_ack <= cfg_req;
      if (cfg_req && !cfg_we) begin
        cfg_rdata <= rd_mux;
      end
    end
  end

  // Registered control outputs
  always_ff @(posedge clk or negedge rst_sync_n) begin
    if (!rst_sync_n) begin
      gp_enable        <= 1'b0;
      gp_rate          <= '0;
      above_4gb_enable <= 1'b0;
      sideband_enable  <= 1'b0;
      gp_request_depth <= '0;
      power_state      <= CPC_PWR_D0;
    end else begin
      gp_enable        <= gp_ctrl_reg[CPC_GPC_EN_BIT] && strap_sync;
      gp_rate          <= gp_ctrl_reg[CPC_GPC_RATE_LSB +: 3];
      above_4gb_enable <= gp_ctrl_reg[CPC_GPC_4GB_BIT];
      sideband_enable  <= gp_ctrl_reg[CPC_GPC_SBA_BIT];
      gp_request_depth <= gp_ctrl_reg[CPC_GPC_DEPTH_LSB +: 8];
      power_state      <= pwr_state_int;
    end
  end

endmodule : cpc_cfg_regs
`default_nettype wire

// file: core/cpc_pkg.sv
// Package: offsets, field positions and reset values of the configuration capability bank
`default_nettype none
package cpc_pkg;

  // Configuration dword byte offsets
  localparam logic [7:0] CPC_OFF_CAP_PTR      = 8'h34;
  localparam logic [7:0] CPC_OFF_PLANT_CODE   = 8'h40;
  localparam logic [7:0] CPC_OFF_STATUS_ALIAS = 8'h44;
  localparam logic [7:0] CPC_OFF_SCRATCHPAD   = 8'h48;
  localparam logic [7:0] CPC_OFF_GP_CAP_ID    = 8'h54;
  localparam logic [7:0] CPC_OFF_GP_CAPS      = 8'h58;
  localparam logic [7:0] CPC_OFF_GP_CTRL      = 8'h5C;
  localparam logic [7:0] CPC_OFF_PWR_CAP_ID   = 8'h60;
  localparam logic [7:0] CPC_OFF_PWR_CTRL     = 8'h64;

  // Capability list values
  localparam logic [31:0] CPC_CAP_PTR_GP      = 32'h0000_0054;
  localparam logic [31:0] CPC_CAP_PTR_PWR     = 32'h0000_0060;
  localparam logic [7:0]  CPC_GP_CAP_ID       = 8'h02;
  localparam logic [7:0]  CPC_GP_NEXT_PTR     = 8'h60;
  localparam logic [7:0]  CPC_PWR_CAP_ID      = 8'h01;
  localparam logic [7:0]  CPC_PWR_NEXT_PTR    = 8'h00;
  localparam logic [2:0]  CPC_PWR_VERSION     = 3'h1;

  // Graphics port capabilities defaults
  localparam logic [2:0]  CPC_GP_RATES_DEF    = 3'h3;
  localparam logic        CPC_GP_4GB_DEF      = 1'b1;
  localparam logic [7:0]  CPC_GP_REQUEST_QUEUE_DEPTH_DEF = 8'h07;

  // Graphics port control field positions
  localparam int CPC_GPC_RATE_LSB   = 0;
  localparam int CPC_GPC_4GB_BIT    = 5;
  localparam int CPC_GPC_EN_BIT     = 8;
  localparam int CPC_GPC_SBA_BIT    = 9;
  localparam int CPC_GPC_DEPTH_LSB  = 24;

  // Power control field positions and values
  localparam int CPC_PWC_SEL_LSB    = 9;
  localparam int CPC_PWC_SCALE_LSB  = 13;
  localparam int CPC_PWC_DATA_LSB   = 24;
  localparam logic [1:0] CPC_PWR_D0 = 2'h0;
  localparam logic [1:0] CPC_PWR_D3 = 2'h3;

  // Reset values
  localparam logic [31:0] CPC_SCRATCH_RST = 32'h0000_0000;
  localparam logic [27:0] CPC_PLANT_SCRATCH_RST = 28'h000_0000;

endpackage : cpc_pkg
`default_nettype wire

// file: core/cpc_pwr_ctrl.sv
// Power control and status register
`default_nettype none
module cpc_pwr_ctrl
  import cpc_pkg::*;
(
  // Clock and reset
  input  wire logic        clk,
  input  wire logic        rst_n,
  // Write strobe with merged data
  input  wire logic        wr_en,
  input  wire logic [31:0] wr_data,
  // Data reported for the selected item
  input  wire logic [7:0]  data_value,
  // Register state
  output logic      [1:0]  power_state,
  output logic      [31:0] rd_word
);

  logic [3:0] data_sel_reg;
  logic [1:0] data_scale_reg;
  logic [7:0] data_reg;
  wire  [1:0] wr_state    = wr_data[1:0];
  wire        state_legal = (wr_state == CPC_PWR_D0) || (wr_state == CPC_PWR_D3);

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      power_state    <= CPC_PWR_D0;
      data_sel_reg   <= '0;
      data_scale_reg <= '0;
      data_reg       <= '0;
    end else begin
      data_reg <= data_value;
      if (wr_en && state_legal) begin
        power_state <= wr_state;
      end
      if (wr_en) begin
        data_sel_reg   <= wr_data[CPC_PWC_SEL_LSB +: 4];
        data_scale_reg <= wr_data[CPC_PWC_SCALE_LSB +: 2];
      end
    end
  end

  // Reserved and sticky bits read zero
  assign rd_word = {data_reg, 9'h000, data_scale_reg, data_sel_reg, 7'h00, power_state};

endmodule : cpc_pwr_ctrl
`default_nettype wire

// file: core/cpc_sync.sv
// Two flip-flop synchroniser for pin-level inputs
`default_nettype none
module cpc_sync #(
  parameter int WIDTH = 1
) (
  // Clock and reset
  input  wire logic             clk,
  input  wire logic             rst_n,
  // Data
  input  wire logic [WIDTH-1:0] async_in,
  output logic      [WIDTH-1:0] sync_out
);

  logic [WIDTH-1:0] stage1_reg;

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      stage1_reg <= '0;
      sync_out   <= '0;
    end else begin
      stage1_reg <= async_in;
      sync_out   <= stage1_reg;
    end
  end

endmodule : cpc_sync
`default_nettype wire

// file: tb/cpc_cfg_regs_assertions.sv
// Assertion checker for the configuration capability bank
`default_nettype none
module cpc_cfg_regs_chk
  import cpc_pkg::*;
#(
  parameter logic [3:0] PLANT_CODE = 4'hA
) (
  // Clock and reset
  input wire logic        clk,
  input wire logic        rst_n,
  // Configuration access port
  input wire logic        cfg_req,
  input wire logic        cfg_we,
  input wire logic [7:0]  cfg_addr,
  input wire logic [31:0] cfg_rdata,
  // Device-side inputs
  input wire logic [31:0] mmio_status,
  input wire logic        graphics_port_reset,
  // Programmed controls
  input wire logic        gp_enable,
  input wire logic [2:0]  gp_rate,
  input wire logic [7:0]  gp_request_depth,
  input wire logic [1:0]  power_state
);
  timeunit 1ns;
  timeprecision 1ns;

  default clocking cb @(posedge clk); endclocking
  default disable iff (!rst_n);

  wire logic rd_req;
  assign rd_req = cfg_req && !cfg_we;

  plant_code_read_a: assert property (
    rd_req && cfg_addr == CPC_OFF_PLANT_CODE |=> cfg_rdata[3:0] == PLANT_CODE) else $error("plant code wrong");
  status_alias_a: assert property (
    rd_req && cfg_addr == CPC_OFF_STATUS_ALIAS |=> cfg_rdata == $past(mmio_status)) else $error("alias wrong");
  cap_pointer_a: assert property (
    rd_req && cfg_addr == CPC_OFF_CAP_PTR |=> cfg_rdata == CPC_CAP_PTR_GP || cfg_rdata == CPC_CAP_PTR_PWR)
    else $error("list pointer wrong");
  power_id_a: assert property (
    rd_req && cfg_addr == CPC_OFF_PWR_CAP_ID |=>
    cfg_rdata == {8'h00, 5'b00100, CPC_PWR_VERSION, CPC_PWR_NEXT_PTR, CPC_PWR_CAP_ID}) else $error("power id wrong");
  ctrl_fields_a: assert property (
    rd_req && cfg_addr == CPC_OFF_GP_CTRL |=> cfg_rdata[31:24] == gp_request_depth && cfg_rdata[2:0] == gp_rate)
    else $error("control fields disagree");
  ctrl_reserved_a: assert property (
    rd_req && cfg_addr == CPC_OFF_GP_CTRL |=> cfg_rdata[23:10] == 14'h0 && cfg_rdata[7:6] == 2'h0
    && cfg_rdata[4:3] == 2'h0) else $error("reserved bits set");
  port_reset_clear_a: assert property (
    graphics_port_reset |=> ##1 !gp_enable) else $error("enable survives port reset");
  power_state_legal_a: assert property (
    power_state == CPC_PWR_D0 || power_state == CPC_PWR_D3) else $error("illegal power state");
endmodule : cpc_cfg_regs_chk

bind cpc_cfg_regs cpc_cfg_regs_chk #(.PLANT_CODE(PLANT_CODE)) i_cpc_cfg_regs_chk (
  .clk(clk), .rst_n(rst_n), .cfg_req(cfg_req), .cfg_we(cfg_we), .cfg_addr(cfg_addr),
  .cfg_rdata(cfg_rdata), .mmio_status(mmio_status), .graphics_port_reset(graphics_port_reset),
  .gp_enable(gp_enable), .gp_rate(gp_rate), .gp_request_depth(gp_request_depth), .power_state(power_state)
);
`default_nettype wire

// file: tb/cpc_host.sv
// Host model issuing configuration cycles to the capability bank
`default_nettype none
module cpc_host (
  // Clock
  input  wire logic        clk,
  // Request side
  output var  logic        cfg_req,
  output var  logic        cfg_we,
  output var  logic [7:0]  cfg_addr,
  output var  logic [3:0]  cfg_be,
  output var  logic [31:0] cfg_wdata,
  // Answer side
  input  wire logic [31:0] cfg_rdata,
  input  wire logic        cfg_ack
);
  timeunit 1ns;
  timeprecision 1ns;

  initial begin
    cfg_req   = 1'b0;
    cfg_we    = 1'b0;
    cfg_addr  = 8'h00;
    cfg_be    = 4'h0;
    cfg_wdata = 32'h0;
  end

  // One-cycle request, then wait a bounded time for the acknowledge
  task automatic xfer(input logic we, input logic [7:0] a, input logic [3:0] be, input logic [31:0] d,
                      output logic [31:0] q, output logic ok);
    int n;
    n = 0;
    @(posedge clk);
    cfg_req   <= 1'b1;
    cfg_we    <= we;
    cfg_addr  <= a;
    cfg_be    <= be;
    cfg_wdata <= d;
    @(posedge clk);
    // Address and data stand until the acknowledge is seen
    cfg_req   <= 1'b0;
    do begin
      @(posedge clk);
      n++;
    end while (cfg_ack !== 1'b1 && n < 4);
    q = cfg_rdata;
    // Acknowledge must come exactly one cycle after the taken edge
    ok = (cfg_ack === 1'b1) && (n == 1);
  endtask : xfer
endmodule : cpc_host
`default_nettype wire

// file: tb/tb_top.sv
// Self-checking bench for the configuration capability bank
`default_nettype none
module tb_top
  import cpc_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ns;

  localparam logic [3:0] PC = 4'h6;  // Arbitrary plant code
  logic        clk, rst_n, strap, gpr, req, we, ack, gpe, a4g, sbe;
  logic [7:0]  pdv, addr, depth;
  logic [3:0]  be;
  logic [2:0]  rate;
  logic [1:0]  pst, st;
  logic [1:0]  pw [4];
  logic [31:0] mmio, wdata, rdata;
  int          cmp_count, bad_count, cyc;

  cpc_cfg_regs #(.PLANT_CODE(PC)) i_cpc_cfg_regs (
    .clk(clk), .rst_n(rst_n), .cfg_req(req), .cfg_we(we), .cfg_addr(addr), .cfg_be(be),
    .cfg_wdata(wdata), .cfg_rdata(rdata), .cfg_ack(ack), .gp_strap_en(strap), .mmio_status(mmio),
    .graphics_port_reset(gpr), .pwr_data_value(pdv), .gp_enable(gpe), .gp_rate(rate),
    .above_4gb_enable(a4g), .sideband_enable(sbe), .gp_request_depth(depth), .power_state(pst));
  cpc_host i_cpc_host (.clk(clk), .cfg_req(req), .cfg_we(we), .cfg_addr(addr), .cfg_be(be),
    .cfg_wdata(wdata), .cfg_rdata(rdata), .cfg_ack(ack));

  always #50 clk = ~clk;

  task automatic finish_test();
    $display("Counts: %0d compares, %0d mismatches", cmp_count, bad_count);
    if (bad_count == 0 && cmp_count > 0) begin
      $display("== PASSED ==");
    end else begin
      $display("== FAILED ==");
    end
    $finish;
  endtask : finish_test

  always @(posedge clk) begin
    cyc <= cyc + 1;
    if (cyc == 3000) begin
      bad_count++;
      finish_test();
    end
  end

  task automatic check(input logic [31:0] got, input logic [31:0] exp);
    cmp_count++;
    if (got !== exp) begin
      bad_count++;
      $display("MISMATCH t=%0t got %h exp %h", $time, got, exp);
    end
  endtask : check

  task automatic rd(input logic [7:0] a, input logic [31:0] exp);
    logic [31:0] q;
    logic        ok;
    i_cpc_host.xfer(1'b0, a, 4'hF, 32'h0, q, ok);
    check(q, exp);
    check({31'h0, ok}, 32'h1);
  endtask : rd

  task automatic wr(input logic [7:0] a, input logic [3:0] b, input logic [31:0] d);
    logic [31:0] q;
    logic        ok;
    i_cpc_host.xfer(1'b1, a, b, d, q, ok);
    check({31'h0, ok}, 32'h1);
  endtask : wr

  initial begin
    clk = 1'b0; rst_n = 1'b0; strap = 1'b0; gpr = 1'b0; pdv = 8'h5A; mmio = 32'h0;
    cmp_count = 0; bad_count = 0; cyc = 0;
    pw = '{2'h3, 2'h1, 2'h0, 2'h2};
    repeat (20) @(posedge clk);
    rst_n <= 1'b1;
    repeat (4) @(posedge clk);
    rd(CPC_OFF_CAP_PTR, 32'h0000_0060);
    rd(CPC_OFF_GP_CAPS, 32'h0);
    wr(CPC_OFF_GP_CTRL, 4'hF, 32'h0700_0321);
    rd(CPC_OFF_GP_CTRL, 32'h0);
    check({31'h0, gpe}, 32'h0);
    $display("test done: port strapped off");
    strap <= 1'b1;
    repeat (4) @(posedge clk);
    rd(CPC_OFF_CAP_PTR, 32'h0000_0054);
    wr(CPC_OFF_GP_CAPS, 4'hF, 32'hFFFF_FFFF);
    rd(CPC_OFF_GP_CAP_ID, 32'h0010_6002);
    rd(CPC_OFF_GP_CAPS, 32'h0700_0223);
    rd(CPC_OFF_GP_CTRL, 32'h0);
    rd(CPC_OFF_PWR_CAP_ID, 32'h0021_0001);
    wr(8'h80, 4'hF, 32'hFFFF_FFFF);
    rd(8'h80, 32'h0);
    $display("test done: identity words");
    rd(CPC_OFF_SCRATCHPAD, 32'h0);
    wr(CPC_OFF_SCRATCHPAD, 4'h5, 32'hA5A5_5A5A);
    rd(CPC_OFF_SCRATCHPAD, 32'h00A5_005A);
    wr(CPC_OFF_PLANT_CODE, 4'hF, 32'hFFFF_FFFF);
    rd(CPC_OFF_PLANT_CODE, {28'hFFF_FFFF, PC});
    mmio <= 32'h1234_ABCD;
    rd(CPC_OFF_STATUS_ALIAS, 32'h1234_ABCD);
    $display("test done: storage words");
    // Only single-bit rates are written, reserved bits all set
    for (int r = 1; r <= 2; r++) begin
      wr(CPC_OFF_GP_CTRL, 4'hF, {29'h1FFF_FFFF, 3'(r)});
      rd(CPC_OFF_GP_CTRL, {29'h1FE0_0064, 3'(r)});
      check({18'h0, gpe, a4g, sbe, rate, depth}, {18'h0, 3'h7, 3'(r), 8'hFF});
    end
    gpr <= 1'b1;
    @(posedge clk);
    gpr <= 1'b0;
    rd(CPC_OFF_GP_CTRL, 32'hFF00_0222);
    check({31'h0, gpe}, 32'h0);
    $display("test done: port control");
    rd(CPC_OFF_PWR_CTRL, 32'h5A00_0000);
    st = CPC_PWR_D0;
    foreach (pw[i]) begin
      if (pw[i] == CPC_PWR_D0 || pw[i] == CPC_PWR_D3) st = pw[i];
      wr(CPC_OFF_PWR_CTRL, 4'hF, {30'h3FFF_FFFF, pw[i]});
      rd(CPC_OFF_PWR_CTRL, {8'h5A, 9'h0, 6'h3F, 7'h0, st});
      check({30'h0, pst}, {30'h0, st});
    end
    $display("test done: power control");
    finish_test();
  end
endmodule : tb_top
`default_nettype wire
